// *** hw/ssi_pkg.sv ***
// Constants, types and helpers for the supply status indicator
// Summary of operation
// R1: Green, red, yellow indicators encode supply state
// R2: Contacts and indicators share one state selection
// R3: Priority rises init/ready, first warning, second warning, fault
// R4: Higher priority condition displaces display immediately
// R5: Lower state only after four seconds shown
// R6: Init flashes green; ready steady green
// R7: Rectifier, resistor overload or phase loss: first warning
// R8: First warning: yellow single flash, first contact opens
// R9: Power failure: second warning, double flash, second opens
// R10: Fault: green, yellow off, ready contact open
// R11: Red flash count names the fault cause
// R12: Overloaded resistor: 5 s, then cool first
// R13: Flash timing from clock-derived counts with pause
package ssi_pkg;
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned TICK_PERIOD_US = 1000;
	localparam int unsigned TICK_CYCLES_DEF = (TICK_PERIOD_US * 1000) / CLK_PERIOD_NS;
	// Millisecond times, converted to whole ticks (least times round up)
	localparam int unsigned HOLD_MS = 4000;
	localparam int unsigned CHOP_GRACE_MS = 5000;
	localparam int unsigned FLASH_HALF_MS = 500;
	localparam int unsigned PULSE_ON_MS = 200;
	localparam int unsigned PULSE_OFF_MS = 200;
	localparam int unsigned GROUP_PAUSE_MS = 1000;
	localparam int unsigned HOLD_TICKS_DEF = (HOLD_MS * 1000 + TICK_PERIOD_US - 1) / TICK_PERIOD_US;
	localparam int unsigned CHOP_TICKS_DEF =
		(CHOP_GRACE_MS * 1000 + TICK_PERIOD_US - 1) / TICK_PERIOD_US;
	localparam int TW = 16;
	localparam logic [TW-1:0] FLASH_HALF_TICKS =
		TW'((FLASH_HALF_MS * 1000 + TICK_PERIOD_US - 1) / TICK_PERIOD_US);
	localparam logic [TW-1:0] PULSE_ON_TICKS =
		TW'((PULSE_ON_MS * 1000 + TICK_PERIOD_US - 1) / TICK_PERIOD_US);
	localparam logic [TW-1:0] PULSE_OFF_TICKS =
		TW'((PULSE_OFF_MS * 1000 + TICK_PERIOD_US - 1) / TICK_PERIOD_US);
	localparam logic [TW-1:0] GROUP_PAUSE_TICKS =
		TW'((GROUP_PAUSE_MS * 1000 + TICK_PERIOD_US - 1) / TICK_PERIOD_US);
	// Flash counts per state and fault cause
	localparam logic [2:0] CNT_NONE = 3'h0;
	localparam logic [2:0] CNT_WARN1 = 3'h1;
	localparam logic [2:0] CNT_WARN2 = 3'h2;
	localparam logic [2:0] FLT_RECT_TEMP = 3'h1;
	localparam logic [2:0] FLT_OVERVOLT = 3'h2;
	localparam logic [2:0] FLT_CHOP_SHORT = 3'h3;
	localparam logic [2:0] FLT_GRID = 3'h4;
	localparam logic [2:0] FLT_SHORT_LINK = 3'h5;
	typedef enum logic [2:0] {
		DISP_INIT = 3'h0,
		DISP_READY = 3'h1,
		DISP_WARN1 = 3'h2,
		DISP_WARN2 = 3'h3,
		DISP_FAULT = 3'h4
	} ssi_disp_t;
	typedef enum logic [1:0] {
		BL_IDLE = 2'h0,
		BL_ON = 2'h1,
		BL_OFF = 2'h2,
		BL_PAUSE = 2'h3
	} ssi_blink_t;
	typedef enum logic [1:0] {
		CH_RUN = 2'h0,
		CH_GRACE = 2'h1,
		CH_LOCK = 2'h2
	} ssi_chop_t;
	function automatic logic [1:0] ssi_level(input ssi_disp_t s);
		case (s)
			DISP_WARN1: ssi_level = 2'h1;
			DISP_WARN2: ssi_level = 2'h2;
			DISP_FAULT: ssi_level = 2'h3;
			default: ssi_level = 2'h0;
		endcase
	endfunction
endpackage

// *** hw/ssi_blink_gen.sv ***
// Steady flash and counted flash group pattern generator
`timescale 1ns/1ps
module ssi_blink_gen (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic tick,
	input wire logic [2:0] count,
	output logic flash,
	output logic burst
);
	import ssi_pkg::*;

	logic [TW-1:0] fl_cnt_q;
	logic [TW-1:0] fl_cnt_d;
	logic flash_q;
	logic flash_d;
	ssi_blink_t st_q;
	ssi_blink_t st_d;
	logic [TW-1:0] ph_q;
	logic [TW-1:0] ph_d;
	logic [2:0] done_q;
	logic [2:0] done_d;
	logic [2:0] cnt_q;
	logic [2:0] cnt_d;
	logic burst_q;
	logic burst_d;

	always_comb begin
		fl_cnt_d = fl_cnt_q;
		flash_d = flash_q;
		st_d = st_q;
		ph_d = ph_q;
		done_d = done_q;
		cnt_d = count;
		if (tick) begin
			if (fl_cnt_q == FLASH_HALF_TICKS - 1'b1) begin
				fl_cnt_d = '0;
				flash_d = ~flash_q;
			end else begin
				fl_cnt_d = fl_cnt_q + 1'b1;
			end
		end
		// A new count restarts the group so no mixed count is ever shown
		if (count != cnt_q) begin
			st_d = (count == CNT_NONE) ? BL_IDLE : BL_ON;
			ph_d = '0;
			done_d = 3'h0;
		end else if (tick) begin
			case (st_q)
				BL_IDLE: begin
					ph_d = '0;
				end
				BL_ON: begin
					if (ph_q == PULSE_ON_TICKS - 1'b1) begin
						ph_d = '0;
						done_d = done_q + 3'h1;
						st_d = (done_q + 3'h1 == cnt_q) ? BL_PAUSE : BL_OFF; // [R13]
					end else begin
						ph_d = ph_q + 1'b1;
					end
				end
				BL_OFF: begin
					if (ph_q == PULSE_OFF_TICKS - 1'b1) begin
						ph_d = '0;
						st_d = BL_ON;
					end else begin
						ph_d = ph_q + 1'b1;
					end
				end
				BL_PAUSE: begin
					if (ph_q == GROUP_PAUSE_TICKS - 1'b1) begin // [R13]
						ph_d = '0;
						done_d = 3'h0;
						st_d = BL_ON;
					end else begin
						ph_d = ph_q + 1'b1;
					end
				end
				default: begin
					st_d = BL_IDLE;
				end
			endcase
		end
		burst_d = (st_d == BL_ON);
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			fl_cnt_q <= '0;
			flash_q <= 1'b0;
			st_q <= BL_IDLE;
			ph_q <= '0;
			done_q <= 3'h0;
			cnt_q <= CNT_NONE;
			burst_q <= 1'b0;
		end else begin
			fl_cnt_q <= fl_cnt_d;
			flash_q <= flash_d;
			st_q <= st_d;
			ph_q <= ph_d;
			done_q <= done_d;
			cnt_q <= cnt_d;
			burst_q <= burst_d;
		end
	end

	assign flash = flash_q;
	assign burst = burst_q;
endmodule // ssi_blink_gen

// *** hw/ssi_supply_status.sv ***
// Supply module status selection, indicator and relay contact drive
`timescale 1ns/1ps
module ssi_supply_status #(
	parameter int unsigned TICK_CYCLES = ssi_pkg::TICK_CYCLES_DEF,
	parameter int unsigned HOLD_TICKS = ssi_pkg::HOLD_TICKS_DEF,
	parameter int unsigned CHOP_TICKS = ssi_pkg::CHOP_TICKS_DEF
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic dc_link_charged,
	input wire logic warn_rect_overload,
	input wire logic warn_brake_res_overload,
	input wire logic warn_phase_lost,
	input wire logic warn_power_fail,
	input wire logic flt_rect_overtemp,
	input wire logic flt_overvoltage,
	input wire logic flt_chopper_short,
	input wire logic flt_grid_power,
	input wire logic flt_shorted_link,
	input wire logic brake_demand,
	input wire logic brake_res_critical,
	output logic led_green_q,
	output logic led_red_q,
	output logic led_yellow_q,
	output logic ready_contact_q,
	output logic first_level_alert_contact_q,
	output logic second_level_alert_contact_q,
	output ssi_pkg::ssi_disp_t shown_state_q,
	output logic [2:0] fault_code_q,
	output logic brake_chopper_en_q
);
	import ssi_pkg::*;

	// Millisecond enable divider
	// Free-running, so tick spacing never depends on the display
	logic [31:0] div_q;
	logic [31:0] div_d;
	logic tick_q;
	logic tick_d;

	always_comb begin
		div_d = div_q + 32'h1;
		tick_d = 1'b0;
		if (div_q >= TICK_CYCLES - 1) begin // [R13]
			div_d = 32'h0;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			div_q <= 32'h0;
			tick_q <= 1'b0;
		end else begin
			div_q <= div_d;
			tick_q <= tick_d;
		end
	end

	// Candidate state from the live conditions
	localparam logic [2:0] FLT_CODE [5] = '{
		FLT_RECT_TEMP,
		FLT_OVERVOLT,
		FLT_CHOP_SHORT,
		FLT_GRID,
		FLT_SHORT_LINK
	};
	ssi_disp_t cand;
	logic [2:0] cand_code;
	logic any_fault;
	logic any_warn1;
	logic [4:0] flt_vec;
	logic [4:0] flt_first;
	logic [2:0] code_acc [6];

	assign flt_vec = {flt_shorted_link, flt_grid_power, flt_chopper_short, flt_overvoltage,
		flt_rect_overtemp};
	assign code_acc[0] = CNT_NONE;

	// Several faults at once: the lowest cause number is shown
	for (genvar g = 0; g < 5; g++) begin : g_cause
		if (g == 0) begin : g_lowest
			assign flt_first[g] = flt_vec[g];
		end else begin : g_higher
			assign flt_first[g] = flt_vec[g] && (flt_vec[g-1:0] == '0);
		end
		assign code_acc[g+1] = code_acc[g] | (flt_first[g] ? FLT_CODE[g] : 3'h0); // [R11]
	end

	always_comb begin
		any_fault = |flt_vec;
		any_warn1 = warn_rect_overload | warn_brake_res_overload | warn_phase_lost; // [R7]
		cand_code = code_acc[5];
		if (any_fault) begin // [R3]
			cand = DISP_FAULT;
		end else if (warn_power_fail) begin // [R9]
			cand = DISP_WARN2;
		end else if (any_warn1) begin // [R7]
			cand = DISP_WARN1;
		end else if (dc_link_charged) begin // [R6]
			cand = DISP_READY;
		end else begin
			cand = DISP_INIT;
		end
	end

	// Shown state with the minimum hold before stepping down
	ssi_disp_t shown_q;
	ssi_disp_t shown_d;
	logic [2:0] code_q;
	logic [2:0] code_d;
	logic [31:0] hold_q;
	logic [31:0] hold_d;
	logic [1:0] cand_lvl;
	logic [1:0] shown_lvl;

	always_comb begin
		cand_lvl = ssi_level(cand);
		shown_lvl = ssi_level(shown_q);
		shown_d = shown_q;
		code_d = code_q;
		hold_d = hold_q;
		// Saturates one past the hold so it can never wrap
		if (tick_q && hold_q <= HOLD_TICKS) begin
			hold_d = hold_q + 32'h1;
		end
		if (cand_lvl > shown_lvl) begin // [R4]
			shown_d = cand;
			code_d = cand_code;
			hold_d = 32'h0;
		end else if (cand_lvl == shown_lvl) begin
			// Same level: init/ready swap or fault cause change, no hold needed
			shown_d = cand;
			code_d = cand_code;
		// One tick beyond the hold: a first tick right after the rise cannot cut it short
		end else if (hold_q > HOLD_TICKS) begin // [R5]
			shown_d = cand;
			code_d = cand_code;
			hold_d = 32'h0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			shown_q <= DISP_INIT;
			code_q <= CNT_NONE;
			hold_q <= 32'h0;
		end else begin
			shown_q <= shown_d;
			code_q <= code_d;
			hold_q <= hold_d;
		end
	end

	// Pattern source shared by the yellow and red indicators
	logic [2:0] blink_count;
	logic flash;
	logic burst;

	always_comb begin
		case (shown_q)
			DISP_WARN1: blink_count = CNT_WARN1; // [R8]
			DISP_WARN2: blink_count = CNT_WARN2; // [R9]
			DISP_FAULT: blink_count = code_q; // [R11]
			default: blink_count = CNT_NONE;
		endcase
	end

	ssi_blink_gen ssi_blink_gen_i (
		.clk_sys(clk_sys),
		.rst(rst),
		.tick(tick_q),
		.count(blink_count),
		.flash(flash),
		.burst(burst)
	);

	// Indicators and contacts, both from shown_q only; contact 1 means closed
	logic green_d;
	logic red_d;
	logic yellow_d;
	logic ready_d;
	logic alert1_d;
	logic alert2_d;
	ssi_disp_t shown_state_d;
	logic [2:0] fault_code_d;

	always_comb begin
		green_d = 1'b0;
		red_d = 1'b0;
		yellow_d = 1'b0;
		ready_d = 1'b0;
		alert1_d = 1'b1;
		alert2_d = 1'b1;
		shown_state_d = shown_q; // [R2]
		// Cause code reads zero outside the fault state
		fault_code_d = CNT_NONE;
		case (shown_q) // [R2]
			DISP_INIT: begin
				green_d = flash; // [R6]
			end
			DISP_READY: begin
				green_d = 1'b1; // [R6]
				ready_d = 1'b1;
			end
			DISP_WARN1: begin
				green_d = 1'b1; // [R8]
				yellow_d = burst;
				ready_d = 1'b1;
				alert1_d = 1'b0;
			end
			DISP_WARN2: begin
				green_d = 1'b1; // [R9]
				yellow_d = burst;
				ready_d = 1'b1;
				alert2_d = 1'b0;
			end
			DISP_FAULT: begin
				red_d = burst; // [R10]
				fault_code_d = code_q; // [R11]
			end
			default: begin
				ready_d = 1'b0;
			end
		endcase
	end

	// While held in reset everything reads as a switched-off module
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			led_green_q <= 1'b0;
			led_red_q <= 1'b0;
			led_yellow_q <= 1'b0;
			ready_contact_q <= 1'b0;
			first_level_alert_contact_q <= 1'b0;
			second_level_alert_contact_q <= 1'b0;
			shown_state_q <= DISP_INIT;
			fault_code_q <= CNT_NONE;
		end else begin
			led_green_q <= green_d; // [R1]
			led_red_q <= red_d;
			led_yellow_q <= yellow_d;
			ready_contact_q <= ready_d;
			first_level_alert_contact_q <= alert1_d;
			second_level_alert_contact_q <= alert2_d;
			shown_state_q <= shown_state_d;
			fault_code_q <= fault_code_d;
		end
	end

	// Brake chopper permission under resistor overload
	ssi_chop_t ch_q;
	ssi_chop_t ch_d;
	logic [31:0] grace_q;
	logic [31:0] grace_d;
	logic chop_en_d;

	always_comb begin
		ch_d = ch_q;
		grace_d = grace_q;
		case (ch_q)
			CH_RUN: begin
				grace_d = 32'h0;
				if (warn_brake_res_overload) begin
					ch_d = CH_GRACE;
				end
			end
			CH_GRACE: begin
				if (!warn_brake_res_overload) begin
					ch_d = CH_RUN;
				end else if (grace_q >= CHOP_TICKS) begin // [R12]
					ch_d = CH_LOCK;
				end else if (tick_q) begin
					grace_d = grace_q + 32'h1;
				end
			end
			CH_LOCK: begin
				// Reopen only once the resistor left its critical temperature
				if (!brake_res_critical) begin // [R12]
					ch_d = CH_RUN;
				end
			end
			default: begin
				ch_d = CH_RUN;
			end
		endcase
		chop_en_d = brake_demand && (ch_d != CH_LOCK);
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ch_q <= CH_RUN;
			grace_q <= 32'h0;
			brake_chopper_en_q <= 1'b0;
		end else begin
			ch_q <= ch_d;
			grace_q <= grace_d;
			brake_chopper_en_q <= chop_en_d;
		end
	end
endmodule // ssi_supply_status

// *** verification/ssi_supervisor.sv ***
// Supervisory controller model that decodes the status relay contacts
`timescale 1ns/1ps
module ssi_supervisor (
	input wire logic ready_contact_q,
	input wire logic first_level_alert_contact_q,
	input wire logic second_level_alert_contact_q,
	output logic [2:0] stop_demand
);
	// Open means alarm, so a broken wire also stops the drives
	always_comb begin
		case ({ready_contact_q, first_level_alert_contact_q, second_level_alert_contact_q})
			3'b111: stop_demand = 3'h0;
			3'b101: stop_demand = 3'h1;
			3'b110: stop_demand = 3'h2;
			3'b011: stop_demand = 3'h3;
			default: stop_demand = 3'h4;
		endcase
	end
endmodule // ssi_supervisor

// *** verification/ssi_supply_status_asserts.sv ***
// Port-level assertions for the supply status indicator
`timescale 1ns/1ps
module ssi_status_chk #(
	parameter int unsigned TICK_CYCLES = 4,
	parameter int unsigned HOLD_TICKS = 10,
	parameter int unsigned CHOP_TICKS = 8
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic warn_power_fail,
	input wire logic flt_rect_overtemp,
	input wire logic flt_overvoltage,
	input wire logic flt_chopper_short,
	input wire logic flt_grid_power,
	input wire logic flt_shorted_link,
	input wire logic brake_demand,
	input wire logic led_green_q,
	input wire logic led_red_q,
	input wire logic led_yellow_q,
	input wire logic ready_contact_q,
	input wire logic first_level_alert_contact_q,
	input wire logic second_level_alert_contact_q,
	input wire ssi_pkg::ssi_disp_t shown_state_q,
	input wire logic [2:0] fault_code_q,
	input wire logic brake_chopper_en_q
);
	import ssi_pkg::*;
	// Four seconds of display, counted in clock cycles
	localparam int HOLD_CYC = HOLD_TICKS * TICK_CYCLES;
	logic [4:0] flts;
	logic [2:0] con, led, low;
	logic [1:0] lvl, lvl_q;
	logic [31:0] dwell_q, dwell_d;
	assign flts = {flt_shorted_link, flt_grid_power, flt_chopper_short, flt_overvoltage,
		flt_rect_overtemp};
	assign con = {ready_contact_q, first_level_alert_contact_q, second_level_alert_contact_q};
	assign led = {led_green_q, led_red_q, led_yellow_q};
	always_comb begin
		lvl = (shown_state_q == DISP_FAULT) ? 2'h3 : (shown_state_q == DISP_WARN2) ? 2'h2 :
			(shown_state_q == DISP_WARN1) ? 2'h1 : 2'h0;
		low = 3'h0;
		for (int i = 4; i >= 0; i--) begin
			if (flts[i]) begin
				low = 3'(i + 1);
			end
		end
		// A new fault cause keeps the hold running
		dwell_d = (rst || lvl != lvl_q) ? 32'h0 : dwell_q + 32'(dwell_q != 32'hffffffff);
	end
	always_ff @(posedge clk_sys) begin
		lvl_q <= lvl;
		dwell_q <= dwell_d;
	end
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	a_fault_view: assert property (
		shown_state_q == DISP_FAULT |-> con == 3'b011 && !led[2] && !led[0]) else $error("fault");
	a_warn1_view: assert property (
		shown_state_q == DISP_WARN1 |-> con == 3'b101 && led[2:1] == 2'b10) else $error("warn1");
	a_warn2_view: assert property (
		shown_state_q == DISP_WARN2 |-> con == 3'b110 && led[2:1] == 2'b10) else $error("warn2");
	a_ready_view: assert property (
		shown_state_q == DISP_READY |-> con == 3'b111 && led == 3'b100) else $error("ready");
	a_init_view: assert property (
		shown_state_q == DISP_INIT && !$past(rst) && !$past(rst, 2) |-> con == 3'b011
		&& led[1:0] == 2'h0) else $error("init");
	a_fault_first: assert property (
		(!rst && flts != 5'h0)[*3] |-> shown_state_q == DISP_FAULT) else $error("fault late");
	a_warn2_first: assert property (
		(!rst && warn_power_fail && flts == 5'h0 && shown_state_q != DISP_FAULT)[*3]
		|-> shown_state_q == DISP_WARN2) else $error("warn2 late");
	a_fault_cause: assert property (
		(!rst && flts != 5'h0 && $stable(flts))[*3] |-> fault_code_q == low) else $error("cause");
	a_hold_min: assert property (
		lvl < lvl_q |-> dwell_q >= HOLD_CYC) else $error("hold short");
	a_chop_demand: assert property (
		brake_chopper_en_q |-> $past(brake_demand)) else $error("chopper");
endmodule // ssi_status_chk
bind ssi_supply_status ssi_status_chk #(.TICK_CYCLES(TICK_CYCLES), .HOLD_TICKS(HOLD_TICKS),
	.CHOP_TICKS(CHOP_TICKS)) ssi_status_chk_i (.*);

// *** verification/ssi_supply_status_tb.sv ***
// Self-checking bench for the supply status indicator
`timescale 1ns/1ps
module ssi_supply_status_tb;
	import ssi_pkg::*;
	logic clk_sys = 1'b0, rst = 1'b1, dc_link_charged = 1'b0;
	logic brake_demand = 1'b0, brake_res_critical = 1'b0;
	logic [3:0] wrn = 4'h0;
	logic [4:0] flt = 5'h0;
	logic led_green_q, led_red_q, led_yellow_q, ready_contact_q, brake_chopper_en_q;
	logic first_level_alert_contact_q, second_level_alert_contact_q;
	logic [2:0] fault_code_q, stop_demand;
	ssi_disp_t shown_state_q;
	int miscompares = 0, checks_done = 0, n;
	wire [2:0] leds = {led_yellow_q, led_red_q, led_green_q};
	always #2.5 clk_sys = ~clk_sys;
	ssi_supply_status #(.TICK_CYCLES(4), .HOLD_TICKS(10), .CHOP_TICKS(8)) ssi_supply_status_i (
		.warn_rect_overload(wrn[0]), .warn_brake_res_overload(wrn[1]), .warn_phase_lost(wrn[2]),
		.warn_power_fail(wrn[3]), .flt_rect_overtemp(flt[0]), .flt_overvoltage(flt[1]),
		.flt_chopper_short(flt[2]), .flt_grid_power(flt[3]), .flt_shorted_link(flt[4]), .*);
	ssi_supervisor ssi_supervisor_i (.*);
	task automatic end_of_test;
		if (miscompares == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	task automatic chk(input string what, input logic [2:0] got, input logic [2:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic put(input logic [4:0] f, input logic [3:0] w);
		@(posedge clk_sys);
		flt <= f;
		wrn <= w;
	endtask
	task automatic view(input ssi_disp_t s, input logic [2:0] d, input logic g);
		chk("state", shown_state_q, s);
		chk("contacts", stop_demand, d);
		chk("green", 3'(led_green_q), 3'(g));
	endtask
	task automatic rises(input int w, input int len);
		logic p;
		n = 0;
		repeat (len) begin
			p = leds[w];
			cyc(1);
			n += int'(leds[w] === 1'b1 && p === 1'b0);
		end
	endtask
	// Sync to a rise, then one group must hold exactly k pulses
	task automatic grp(input int w, input int k);
		repeat (16000) if (leds[w] !== 1'b0) cyc(1);
		repeat (16000) if (leds[w] !== 1'b1) cyc(1);
		rises(w, 1600 * k + 3192);
		chk("flashes", 3'(n), 3'(k - 1));
		rises(w, 16);
		chk("group", 3'(n), 3'h1);
	endtask
	initial begin
		#400000;
		miscompares++;
		end_of_test();
	end
	initial begin
		cyc(7);
		view(DISP_INIT, 3'h4, 1'b0);
		@(posedge clk_sys);
		rst <= 1'b0;
		cyc(4);
		view(DISP_INIT, 3'h3, 1'b0);
		rises(0, 4400);
		chk("blink", 3'(n), 3'h1);
		@(posedge clk_sys);
		dc_link_charged <= 1'b1;
		cyc(3);
		view(DISP_READY, 3'h0, 1'b1);
		for (int i = 0; i < 3; i++) begin
			put(5'h0, 4'(1 << i));
			cyc(3);
			view(DISP_WARN1, 3'h1, 1'b1);
			put(5'h0, 4'h0);
			cyc(20);
			view(DISP_WARN1, 3'h1, 1'b1);
			cyc(40);
			view(DISP_READY, 3'h0, 1'b1);
		end
		@(posedge clk_sys);
		brake_demand <= 1'b1;
		brake_res_critical <= 1'b1;
		put(5'h0, 4'h2);
		cyc(20);
		chk("chopper", 3'(brake_chopper_en_q), 3'h1);
		cyc(30);
		chk("chopper", 3'(brake_chopper_en_q), 3'h0);
		put(5'h0, 4'h1);
		cyc(20);
		chk("chopper", 3'(brake_chopper_en_q), 3'h0);
		@(posedge clk_sys);
		brake_res_critical <= 1'b0;
		cyc(3);
		chk("chopper", 3'(brake_chopper_en_q), 3'h1);
		grp(2, 1);
		put(5'h0, 4'h9);
		cyc(3);
		view(DISP_WARN2, 3'h2, 1'b1);
		grp(2, 2);
		put(5'h1f, 4'h9);
		cyc(3);
		view(DISP_FAULT, 3'h3, 1'b0);
		chk("yellow", 3'(led_yellow_q), 3'h0);
		for (int k = 0; k < 5; k++) begin
			put(5'(5'h1f << k), 4'h9);
			cyc(3);
			chk("cause", fault_code_q, 3'(k + 1));
		end
		grp(1, 5);
		put(5'h0, 4'h9);
		cyc(3);
		view(DISP_WARN2, 3'h2, 1'b1);
		chk("red", 3'(led_red_q), 3'h0);
		end_of_test();
	end
endmodule // ssi_supply_status_tb
